//--- pkg/dea_pkg.sv
package dea_pkg;
  // ==========================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int ADDR_LOW_W = 8;
  localparam int ADDR_HIGH_W = 2;
  localparam int PADDR_W = 14;
  localparam int APB_DATA_W = 32;
  localparam int SYNC_STAGES = 3;
  localparam int RESET_INPUTS = 2;

  // ==========================================
  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_FLAGS = 12'hfa1;
  localparam logic [11:0] IDX_CONTROL = 12'hfa6;
  localparam logic [11:0] IDX_UNLOCK = 12'hfa7;
  localparam logic [11:0] IDX_DATA = 12'hfa8;
  localparam logic [11:0] IDX_ADDR_LOW = 12'hfa9;
  localparam logic [11:0] IDX_ADDR_HIGH = 12'hfaa;
  localparam logic [PADDR_W-1:0] ADR_FLAGS = {IDX_FLAGS, 2'h0};
  localparam logic [PADDR_W-1:0] ADR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [PADDR_W-1:0] ADR_UNLOCK = {IDX_UNLOCK, 2'h0};
  localparam logic [PADDR_W-1:0] ADR_DATA = {IDX_DATA, 2'h0};
  localparam logic [PADDR_W-1:0] ADR_ADDR_LOW = {IDX_ADDR_LOW, 2'h0};
  localparam logic [PADDR_W-1:0] ADR_ADDR_HIGH = {IDX_ADDR_HIGH, 2'h0};

  // ==========================================
  // control register fields
  localparam int BIT_READ = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_ERASE = 4;
  localparam int BIT_CFG = 6;
  localparam int BIT_PGM = 7;
  // flag register field
  localparam int BIT_DONE = 4;

  // ==========================================
  // unlock keys
  localparam logic [DATA_W-1:0] KEY_FIRST = 8'h55;
  localparam logic [DATA_W-1:0] KEY_SECOND = 8'haa;

  // ==========================================
  // self-timed write, least time rounded up
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 4000000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {dea_key_idle, dea_key_first, dea_key_armed} dea_key_t;
endpackage

//--- src/dea_mem.sv
`timescale 1ns/1ns
module dea_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic clock,
  input wire logic clock_enable,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  // ==========================================
  // storage array
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clock) begin
    if (clock_enable && wr_en) begin
      cells[addr] <= wdata;
    end
  end

  // ==========================================
  // registered read data
  always_ff @(posedge clock) begin
    if (clock_enable && rd_en) begin
      rdata <= cells[addr];
    end
  end
endmodule // dea_mem

//--- src/dea_top.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - ten-bit address, 1024 byte locations
// - high register gives two upper bits
// - upper six high-address bits read zero
// - unlock port stores nothing, reads zero
// - unlock writes only arm a write
// - 55h then AAh then set write
// - start bits set by one only
// - hardware clears start bits when done
// - one-cycle read, refused when program select
// - write only while write permit set
// - write permit zero after power-up
// - pin or watchdog reset aborts, sets flag
// - such reset zeroes data and address
// - write done flag set, software clears
// - bit 6 selects configuration space
// - bit 7 selects program memory
// - bit 3 holds write abort flag
// - abort keeps select and erase bits
module dea_top
  import dea_pkg::*;
#(
  parameter int WRITE_COUNT = WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset,
  input wire logic watchdog_timeout,
  output logic write_done_flag
);
  localparam int CW = $clog2(WRITE_COUNT + 1);
  localparam logic [CW-1:0] COUNT_LAST = CW'(WRITE_COUNT - 1);
  localparam logic [CW-1:0] COUNT_ZERO = '0;

  // ==========================================
  // state
  logic [ADDR_LOW_W-1:0] addr_low_reg;
  logic [ADDR_HIGH_W-1:0] addr_high_reg;
  logic [DATA_W-1:0] nv_data_reg;
  logic read_start;
  logic read_load;
  logic write_start;
  logic write_permit_bit;
  logic write_abort_flag;
  logic row_erase;
  logic config_space_select;
  logic program_memory_select;
  logic [CW-1:0] write_count;
  dea_key_t key_state;
  logic [SYNC_STAGES-1:0] sync_pipe [RESET_INPUTS];
  logic [RESET_INPUTS-1:0] reset_level;
  logic [RESET_INPUTS-1:0] reset_pins;
  logic device_reset;

  // ==========================================
  // bus decode
  logic access;
  logic wr_access;
  logic prep;
  logic sel_control;
  logic sel_unlock;
  logic sel_data;
  logic sel_low;
  logic sel_high;
  logic sel_flags;
  logic mapped;
  logic [DATA_W-1:0] wbyte;
  logic [DATA_W-1:0] control_view;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_rdata;
  logic write_finish;
  logic mem_wr_en;
  logic locked;
  logic ctl_write;
  logic key_write;
  logic start_write;
  logic next_done;

  assign access = psel && penable && pready;
  assign prep = psel && penable && !pready;
  assign wbyte = pwdata[DATA_W-1:0];
  assign sel_control = paddr == ADR_CONTROL;
  assign sel_unlock = paddr == ADR_UNLOCK;
  assign sel_data = paddr == ADR_DATA;
  assign sel_low = paddr == ADR_ADDR_LOW;
  assign sel_high = paddr == ADR_ADDR_HIGH;
  assign sel_flags = paddr == ADR_FLAGS;
  assign mapped = sel_control || sel_unlock || sel_data || sel_low || sel_high || sel_flags;
  // writes are ignored while a pin or watchdog reset is active
  assign wr_access = access && pwrite && mapped && !device_reset;
  // control, unlock, data and address registers are frozen while a write runs; flags stays writable
  assign locked = write_start;
  assign ctl_write = wr_access && sel_control && !locked;
  assign key_write = wr_access && sel_unlock && !locked;
  assign start_write = ctl_write && wbyte[BIT_WRITE] && key_state == dea_key_armed
    && write_permit_bit;
  assign write_finish = write_start && write_count == COUNT_ZERO && !device_reset;
  assign mem_wr_en = write_finish && !program_memory_select && !config_space_select;
  assign mem_addr = {addr_high_reg, addr_low_reg};
  assign control_view = {program_memory_select, config_space_select, 1'b0, row_erase,
    write_abort_flag, write_permit_bit, write_start, read_start};

  // ==========================================
  // reset pin synchronisers
  assign reset_pins = {watchdog_timeout, external_reset};
  genvar g;
  for (g = 0; g < RESET_INPUTS; g++) begin : g_sync
    always_ff @(posedge clock) begin
      if (reset) begin
        sync_pipe[g] <= '0;
        reset_level[g] <= 1'b0;
      end else if (clock_enable) begin
        sync_pipe[g] <= {sync_pipe[g][SYNC_STAGES-2:0], reset_pins[g]};
        if (sync_pipe[g][SYNC_STAGES-2] == sync_pipe[g][SYNC_STAGES-1]) begin
          reset_level[g] <= sync_pipe[g][SYNC_STAGES-1];
        end
      end
    end
  end
  assign device_reset = |reset_level;

  // ==========================================
  // apb answer, one wait state
  always_ff @(posedge clock) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clock_enable) begin
      if (prep) begin
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= '0;
        if (!pwrite) begin
          unique case (1'b1)
            sel_control: prdata[DATA_W-1:0] <= control_view;
            sel_data: prdata[DATA_W-1:0] <= nv_data_reg;
            sel_low: prdata[ADDR_LOW_W-1:0] <= addr_low_reg;
            sel_high: prdata[ADDR_HIGH_W-1:0] <= addr_high_reg;
            sel_flags: prdata[BIT_DONE] <= write_done_flag;
            default: prdata <= '0;
          endcase
        end
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================
  // address and data registers
  always_ff @(posedge clock) begin
    if (reset || (clock_enable && device_reset)) begin
      addr_low_reg <= '0;
      addr_high_reg <= '0;
    end else if (clock_enable && wr_access && !locked) begin
      if (sel_low) begin
        addr_low_reg <= wbyte;
      end
      if (sel_high) begin
        addr_high_reg <= wbyte[ADDR_HIGH_W-1:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || (clock_enable && device_reset)) begin
      nv_data_reg <= '0;
    end else if (clock_enable) begin
      if (read_load) begin
        nv_data_reg <= config_space_select ? '0 : mem_rdata;
      end else if (wr_access && sel_data && !locked) begin
        nv_data_reg <= wbyte;
      end
    end
  end

  // ==========================================
  // unlock sequence
  always_ff @(posedge clock) begin
    if (reset || (clock_enable && device_reset)) begin
      key_state <= dea_key_idle;
    end else if (clock_enable && wr_access) begin
      if (key_write && wbyte == KEY_FIRST && key_state == dea_key_idle) begin
        key_state <= dea_key_first;
      end else if (key_write && wbyte == KEY_SECOND && key_state == dea_key_first) begin
        key_state <= dea_key_armed;
      end else begin
        key_state <= dea_key_idle;
      end
    end
  end

  // ==========================================
  // read start
  always_ff @(posedge clock) begin
    if (reset || (clock_enable && device_reset)) begin
      read_start <= 1'b0;
      read_load <= 1'b0;
    end else if (clock_enable) begin
      read_load <= read_start;
      if (read_start) begin
        read_start <= 1'b0;
      end else if (ctl_write && wbyte[BIT_READ] && !program_memory_select) begin
        read_start <= 1'b1;
      end
    end
  end

  // ==========================================
  // write start and timer
  always_ff @(posedge clock) begin
    if (reset || (clock_enable && device_reset)) begin
      write_start <= 1'b0;
      write_count <= '0;
    end else if (clock_enable) begin
      if (write_start) begin
        write_count <= write_count - CW'(1);
        if (write_finish) begin
          write_start <= 1'b0;
        end
      end else if (start_write) begin
        write_start <= 1'b1;
        write_count <= COUNT_LAST;
      end
    end
  end

  // ==========================================
  // control bits
  always_ff @(posedge clock) begin
    if (reset) begin
      write_permit_bit <= 1'b0;
      write_abort_flag <= 1'b0;
      row_erase <= 1'b0;
      config_space_select <= 1'b0;
      program_memory_select <= 1'b0;
    end else if (clock_enable) begin
      if (device_reset) begin
        write_permit_bit <= 1'b0;
        if (write_start) begin
          write_abort_flag <= 1'b1;
        end
      end else begin
        if (ctl_write) begin
          write_permit_bit <= wbyte[BIT_PERMIT];
          write_abort_flag <= wbyte[BIT_ABORT];
          config_space_select <= wbyte[BIT_CFG];
          program_memory_select <= wbyte[BIT_PGM];
        end
        if (write_finish) begin
          row_erase <= 1'b0;
        end else if (ctl_write) begin
          row_erase <= wbyte[BIT_ERASE];
        end
      end
    end
  end

  // ==========================================
  // write done flag, set wins over clear
  always_comb begin
    next_done = write_done_flag;
    if (wr_access && sel_flags && !wbyte[BIT_DONE]) begin
      next_done = 1'b0;
    end
    if (write_finish) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      write_done_flag <= 1'b0;
    end else if (clock_enable) begin
      write_done_flag <= next_done;
    end
  end

  // ==========================================
  // data memory
  dea_mem #(
    .WIDTH(DATA_W),
    .DEPTH(MEM_DEPTH),
    .AW(ADDR_W)
  ) u_mem (
    .clock(clock),
    .clock_enable(clock_enable),
    .wr_en(mem_wr_en),
    .rd_en(read_start),
    .addr(mem_addr),
    .wdata(nv_data_reg),
    .rdata(mem_rdata)
  );
endmodule // dea_top

//--- verif/dea_top_properties.sv
`timescale 1ns/1ns
module dea_checker
  import dea_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  input wire logic [APB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_reset,
  input wire logic watchdog_timeout,
  input wire logic write_done_flag
);
  // ======
  // decode
  wire logic mapped = paddr inside {ADR_FLAGS, ADR_CONTROL, ADR_UNLOCK, ADR_DATA,
    ADR_ADDR_LOW, ADR_ADDR_HIGH};
  wire logic fin = psel && penable && pready;
  wire logic rd_fin = fin && !pwrite;
  wire logic clr = fin && pwrite && paddr == ADR_FLAGS && !pwdata[BIT_DONE];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ======
  // properties
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_ready_wait:
    assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
  a_ready_phase:
    assert property (pready |-> psel && penable && $past(penable)) else $error("ready phase");
  a_err_unmapped:
    assert property (fin && !mapped |-> pslverr) else $error("no error");
  a_err_mapped:
    assert property (fin && mapped |-> !pslverr) else $error("false error");
  a_unlock_zero:
    assert property (rd_fin && paddr == ADR_UNLOCK |-> prdata == '0) else $error("unlock");
  a_high_zero:
    assert property (rd_fin && paddr == ADR_ADDR_HIGH |-> prdata[31:2] == '0)
      else $error("high bits");
  a_done_hold:
    assert property (write_done_flag && !clr |=> write_done_flag) else $error("flag lost");
  a_done_clear:
    assert property (clr |=> !write_done_flag) else $error("flag kept");
  a_freeze_hold:
    assert property (!clock_enable |=> $stable(pready) && $stable(prdata)
      && $stable(write_done_flag)) else $error("freeze moved");
endmodule // dea_checker

//--- verif/dea_top_tb.sv
`timescale 1ns/1ns
module dea_top_tb;
  import dea_pkg::*;
  localparam int WC = 20;
  logic clock = 0;
  logic reset = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic ext_rst = 0, wdog = 0;
  logic ce = 1;
  logic [31:0] prdata, rv;
  logic pready, pslverr, write_done_flag, ev;
  int mismatches = 0, checked = 0;
  dea_top #(.WRITE_COUNT(WC)) u_dut (.clock(clock), .reset(reset), .clock_enable(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset(ext_rst),
    .watchdog_timeout(wdog), .write_done_flag(write_done_flag));
  // ======
  // helpers
  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
    checked++;
    if (seen !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", s, e, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdc(input string s, input logic [PADDR_W-1:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    check(s, rv, e);
  endtask
  task automatic go(input logic [31:0] c);
    wr(ADR_CONTROL, c);
    wr(ADR_UNLOCK, {24'h0, KEY_FIRST});
    wr(ADR_UNLOCK, {24'h0, KEY_SECOND});
    wr(ADR_CONTROL, c | 32'h2);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ======
  // scenarios
  task automatic t_reset;
    rdc("control", ADR_CONTROL, 32'h0);
    wr(ADR_ADDR_HIGH, 32'hff);
    rdc("addr high", ADR_ADDR_HIGH, 32'h3);
    wr(ADR_UNLOCK, 32'h77);
    rdc("unlock", ADR_UNLOCK, 32'h0);
    rdc("control", ADR_CONTROL, 32'h0);
    apb(0, 14'h0, 32'h0);
    check("slverr", {31'h0, ev}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_write;
    wr(ADR_ADDR_HIGH, 32'h2);
    wr(ADR_ADDR_LOW, 32'ha5);
    wr(ADR_DATA, 32'h3c);
    go(32'h14);
    rdc("start", ADR_CONTROL, 32'h16);
    check("early", {31'h0, write_done_flag}, 32'h0);
    wr(ADR_CONTROL, 32'h14);
    rdc("held", ADR_CONTROL, 32'h16);
    while (write_done_flag !== 1'b1) begin
      @(posedge clock);
    end
    rdc("end", ADR_CONTROL, 32'h04);
    rdc("flag", ADR_FLAGS, 32'h10);
    wr(ADR_FLAGS, 32'h0);
    check("flag pin", {31'h0, write_done_flag}, 32'h0);
    wr(ADR_DATA, 32'h0);
    wr(ADR_CONTROL, 32'h05);
    rdc("data", ADR_DATA, 32'h3c);
    rdc("rd end", ADR_CONTROL, 32'h04);
    $display("write test done");
  endtask
  task automatic t_freeze;
    go(32'h04);
    ce <= 0;
    repeat (40) @(posedge clock);
    check("frozen", {31'h0, write_done_flag}, 32'h0);
    ce <= 1;
    rdc("resumed", ADR_CONTROL, 32'h06);
    while (write_done_flag !== 1'b1) begin
      @(posedge clock);
    end
    rdc("after", ADR_CONTROL, 32'h04);
    wr(ADR_FLAGS, 32'h0);
    $display("freeze test done");
  endtask
  task automatic t_refuse;
    go(32'h0);
    rdc("no permit", ADR_CONTROL, 32'h0);
    wr(ADR_UNLOCK, 32'h55);
    wr(ADR_UNLOCK, 32'haa);
    wr(ADR_CONTROL, 32'h06);
    rdc("same write", ADR_CONTROL, 32'h04);
    wr(ADR_UNLOCK, 32'h55);
    wr(ADR_DATA, 32'h5a);
    wr(ADR_UNLOCK, 32'haa);
    wr(ADR_CONTROL, 32'h06);
    rdc("bad key", ADR_CONTROL, 32'h04);
    wr(ADR_CONTROL, 32'h41);
    rdc("cfg", ADR_CONTROL, 32'h40);
    rdc("cfg data", ADR_DATA, 32'h0);
    wr(ADR_CONTROL, 32'h0);
    $display("refuse test done");
  endtask
  task automatic t_abort;
    for (int i = 0; i < 2; i++) begin
      wr(ADR_ADDR_LOW, 32'h11);
      wr(ADR_DATA, 32'h22);
      go(32'h94);
      ext_rst <= (i == 0);
      wdog <= (i == 1);
      repeat (8) @(posedge clock);
      ext_rst <= 0;
      wdog <= 0;
      repeat (6) @(posedge clock);
      rdc("abort", ADR_CONTROL, 32'h98);
      rdc("low", ADR_ADDR_LOW, 32'h0);
      rdc("data", ADR_DATA, 32'h0);
      check("no done", {31'h0, write_done_flag}, 32'h0);
      wr(ADR_CONTROL, 32'h81);
      rdc("rd refused", ADR_CONTROL, 32'h80);
      wr(ADR_CONTROL, 32'h0);
    end
    $display("abort test done");
  endtask
  // ======
  // run
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    $display("[FAIL] watchdog exp done seen hang");
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    t_reset();
    t_write();
    t_freeze();
    t_refuse();
    t_abort();
    wrap_up();
  end
endmodule // dea_top_tb
bind dea_top dea_checker u_chk (.clock(clock), .reset(reset), .clock_enable(clock_enable),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_reset(external_reset),
  .watchdog_timeout(watchdog_timeout), .write_done_flag(write_done_flag));
